// ===== adr_defines.svh
/*
  Constants for the acceleration / deceleration ramp generator: register
  offsets, reset values, field codes and timing figures.
  Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef ADR_DEFINES_SVH
`define ADR_DEFINES_SVH

// --------------------------------------------------------------------
// clock and sample tick
// --------------------------------------------------------------------
`define ADR_CLK_MHZ        25
`define ADR_TICK_US        1000
`define ADR_FRAC           16

// --------------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------------
`define ADR_OFS_ACC1       8'h00
`define ADR_OFS_DEC1       8'h04
`define ADR_OFS_REF        8'h08
`define ADR_OFS_ACC2       8'h0C
`define ADR_OFS_DEC2       8'h10
`define ADR_OFS_PAT        8'h14
`define ADR_OFS_BASE       8'h18
`define ADR_OFS_GAIN_A     8'h1C
`define ADR_OFS_GAIN_B     8'h20
`define ADR_OFS_STAT       8'h24
`define ADR_OFS_TERM0      8'h28
`define ADR_TERM_STRIDE    8'h04

// --------------------------------------------------------------------
// ramp times, unit 10 ms
// --------------------------------------------------------------------
`define ADR_TIME_RST_SMALL 20'h001F4
`define ADR_TIME_RST_LARGE 20'h003E8
`define ADR_TIME_MAX       20'h57E40
`define ADR_TIME_SHORT     20'h00003
`define ADR_TIME_FLOOR     20'h00004
`define ADR_CODE_SAME      20'h0270F
`define ADR_TIME_SCALE     64'h000000000000000A

// --------------------------------------------------------------------
// frequencies: reference in Hz, others in 0.01 Hz
// --------------------------------------------------------------------
`define ADR_REF_MIN        9'h001
`define ADR_REF_MAX        9'h190
`define ADR_REF_RST        9'h032
`define ADR_CHZ_PER_HZ     16'h0064
`define ADR_BASE_RST       16'h1388
`define ADR_BASE_MIN       16'h0064

// --------------------------------------------------------------------
// pattern and terminal codes, s-pattern a coefficients
// --------------------------------------------------------------------
`define ADR_PAT_LINEAR     2'h0
`define ADR_PAT_S_A        2'h1
`define ADR_PAT_S_B        2'h2
`define ADR_FN_SECOND_SET  8'h03
`define ADR_S_COEF_SQ      64'h0000000000000004
`define ADR_S_COEF_LIN     64'h0000000000000005
`define ADR_S_COEF_DEN     64'h0000000000000009

`endif

// ===== adr_pkg.sv
/*
  Types shared by the ramp generator files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package adr_pkg;

  // slope calculation sequence
  typedef enum logic [1:0] {
    ADR_CALC_IDLE,
    ADR_CALC_TIME,
    ADR_CALC_STEP
  } adr_calc_state_t;

endpackage

// ===== adr_divider.sv
/*
  Sequential restoring divider, one quotient bit per clock.
  Assumes start_i arrives only while idle and den_i is never zero.
*/
`timescale 1ns/100ps

module adr_divider #(
  parameter int unsigned WIDTH = 64
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  // request
  input  wire logic             start_i,
  input  wire logic [WIDTH-1:0] num_i,
  input  wire logic [WIDTH-1:0] den_i,
  // answer
  output logic      [WIDTH-1:0] quo_o,
  output logic                  done_o
);

  if (WIDTH < 2) begin : g_chk
    $error("adr_divider: WIDTH too small");
  end

  localparam int unsigned CW = $clog2(WIDTH) + 1;

  logic [WIDTH:0]   rem_q;
  logic [WIDTH-1:0] quo_q;
  logic [WIDTH-1:0] den_q;
  logic [CW-1:0]    cnt_q;
  logic             busy_q;
  logic             done_q;
  logic [WIDTH:0]   trial;

  // shifted remainder with the next dividend bit
  always_comb begin
    trial = {rem_q[WIDTH-1:0], quo_q[WIDTH-1]};
  end

  // one bit per cycle while busy
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rem_q  <= '0;
      quo_q  <= '0;
      den_q  <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start_i && !busy_q) begin
        rem_q  <= '0;
        quo_q  <= num_i;
        den_q  <= den_i;
        cnt_q  <= CW'(WIDTH);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (trial >= {1'b0, den_q}) begin
          rem_q <= trial - {1'b0, den_q};
          quo_q <= {quo_q[WIDTH-2:0], 1'b1};
        end else begin
          rem_q <= trial;
          quo_q <= {quo_q[WIDTH-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == CW'(1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign quo_o  = quo_q;
  assign done_o = done_q;

endmodule

// ===== adr_ramp.sv
/*
  Acceleration / deceleration ramp generator: moves the commanded output
  frequency toward the set frequency at a programmed slope.
  Assumes a 25 MHz clock, registers on a plain strobe port, set frequency
  and input terminals synchronous to the clock.
*/
// Summary of operation
// - accel time spans 0 Hz to reference
// - decel time spans reference down to 0 Hz
// - reference 1 to 400 Hz, resets 50
// - ramp times 0 to 3600 s, rating default, second decel resets to 9999
// - select input picks the second time pair
// - second decel code 9999 copies second accel
// - select routed only from terminals coded 3
// - s-pattern a times refer to base frequency
// - s-pattern a above base uses quadratic formula
// - times up to 0.03 s run as 0.04 s
// - reference writes leave both gains unchanged
// - pattern codes 0 linear, 1 a, 2 b
`timescale 1ns/100ps
`include "adr_defines.svh"

module adr_ramp #(
  parameter int unsigned TICK_CYCLES  = `ADR_TICK_US * `ADR_CLK_MHZ,
  parameter bit          LARGE_RATING = 1'b0,
  parameter int unsigned TERM_COUNT   = 5
) (
  // clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_b_i,
  // register port
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [31:0]           reg_rdata_o,
  // input terminals and set frequency
  input  wire logic [TERM_COUNT-1:0] term_in_i,
  input  wire logic [15:0]           set_freq_i,
  // output stage
  output logic      [15:0]           out_freq_o,
  output logic                       ramp_busy_o,
  output logic                       second_set_o
);

  if (TICK_CYCLES < 200 || TERM_COUNT < 1 || TERM_COUNT > 5) begin : g_chk
    $error("adr_ramp: parameter out of range");
  end

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [63:0] adr_sq(input logic [15:0] v);
    adr_sq = 64'(v) * 64'(v);
  endfunction

  function automatic logic [19:0] adr_clamp_time(input logic [31:0] w);
    adr_clamp_time = (w > 32'(`ADR_TIME_MAX)) ? `ADR_TIME_MAX : w[19:0];
  endfunction

  function automatic logic [7:0] adr_term_ofs(input int unsigned k);
    adr_term_ofs = `ADR_OFS_TERM0 + 8'(k) * `ADR_TERM_STRIDE;
  endfunction

  localparam logic [19:0] TIME_RST = LARGE_RATING ? `ADR_TIME_RST_LARGE : `ADR_TIME_RST_SMALL;
  localparam int unsigned TCW      = $clog2(TICK_CYCLES);

  logic [19:0]            acc1_q, dec1_q, acc2_q, dec2_q;
  logic [8:0]             ref_q;
  logic [1:0]             pat_q;
  logic [15:0]            base_q, gain_a_q, gain_b_q;
  logic [7:0]             term_fn_q [TERM_COUNT];
  logic [31:0]            rdata_q;
  logic [TCW-1:0]         tick_cnt_q;
  logic                   tick_q;
  logic [31:0]            acc_q, step_q;
  logic                   busy_q, second_q;
  adr_pkg::adr_calc_state_t calc_q;
  logic [19:0]            tmr_q;
  logic [15:0]            ref_l_q, f_l_q;
  logic [63:0]            div_num_q, div_den_q, div_quo;
  logic                   div_go_q, div_done;
  logic                   sel, rise, s_on;
  logic [31:0]            set_fp;
  logic [19:0]            acc_sel, dec_sel, raw_t, time_c;
  logic [15:0]            f_hi, ref_chz;
  logic [32:0]            up_sum;

  // --------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      acc1_q   <= TIME_RST;
      dec1_q   <= TIME_RST;
      acc2_q   <= TIME_RST;
      dec2_q   <= `ADR_CODE_SAME;
      ref_q    <= `ADR_REF_RST;
      pat_q    <= `ADR_PAT_LINEAR;
      base_q   <= `ADR_BASE_RST;
      gain_a_q <= '0;
      gain_b_q <= '0;
      for (int k = 0; k < TERM_COUNT; k++) begin
        term_fn_q[k] <= '0;
      end
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `ADR_OFS_ACC1:   acc1_q <= adr_clamp_time(reg_wdata_i);
        `ADR_OFS_DEC1:   dec1_q <= adr_clamp_time(reg_wdata_i);
        `ADR_OFS_ACC2:   acc2_q <= adr_clamp_time(reg_wdata_i);
        `ADR_OFS_DEC2:   dec2_q <= adr_clamp_time(reg_wdata_i);
        // reference clamps into range, gains are not touched
        `ADR_OFS_REF: begin
          if (reg_wdata_i < 32'(`ADR_REF_MIN)) begin
            ref_q <= `ADR_REF_MIN;
          end else if (reg_wdata_i > 32'(`ADR_REF_MAX)) begin
            ref_q <= `ADR_REF_MAX;
          end else begin
            ref_q <= reg_wdata_i[8:0];
          end
        end
        `ADR_OFS_PAT: begin
          if (reg_wdata_i <= 32'(`ADR_PAT_S_B)) begin
            pat_q <= reg_wdata_i[1:0];
          end
        end
        `ADR_OFS_BASE: begin
          base_q <= (reg_wdata_i[15:0] < `ADR_BASE_MIN) ? `ADR_BASE_MIN : reg_wdata_i[15:0];
        end
        `ADR_OFS_GAIN_A: gain_a_q <= reg_wdata_i[15:0];
        `ADR_OFS_GAIN_B: gain_b_q <= reg_wdata_i[15:0];
        default: begin
          for (int k = 0; k < TERM_COUNT; k++) begin
            if (reg_addr_i == adr_term_ofs(k)) begin
              term_fn_q[k] <= reg_wdata_i[7:0];
            end
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // register reads, data one cycle after the strobe
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `ADR_OFS_ACC1:   rdata_q <= 32'(acc1_q);
        `ADR_OFS_DEC1:   rdata_q <= 32'(dec1_q);
        `ADR_OFS_REF:    rdata_q <= 32'(ref_q);
        `ADR_OFS_ACC2:   rdata_q <= 32'(acc2_q);
        `ADR_OFS_DEC2:   rdata_q <= 32'(dec2_q);
        `ADR_OFS_PAT:    rdata_q <= 32'(pat_q);
        `ADR_OFS_BASE:   rdata_q <= 32'(base_q);
        `ADR_OFS_GAIN_A: rdata_q <= 32'(gain_a_q);
        `ADR_OFS_GAIN_B: rdata_q <= 32'(gain_b_q);
        `ADR_OFS_STAT:   rdata_q <= {14'h0000, busy_q, second_q, acc_q[31:16]};
        default: begin
          rdata_q <= '0;                                     // unmapped reads zero
          for (int k = 0; k < TERM_COUNT; k++) begin
            if (reg_addr_i == adr_term_ofs(k)) begin
              rdata_q <= 32'(term_fn_q[k]);
            end
          end
        end
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // --------------------------------------------------------------------
  // sample tick divider
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == TCW'(TICK_CYCLES - 1));
      tick_cnt_q <= (tick_cnt_q == TCW'(TICK_CYCLES - 1)) ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // setting selection for the next slope
  // --------------------------------------------------------------------
  always_comb begin
    sel = 1'b0;
    for (int k = 0; k < TERM_COUNT; k++) begin
      sel = sel | (term_in_i[k] && term_fn_q[k] == `ADR_FN_SECOND_SET);
    end
    set_fp  = {set_freq_i, 16'h0000};
    rise    = set_fp > acc_q;
    acc_sel = sel ? acc2_q : acc1_q;
    dec_sel = sel ? ((dec2_q == `ADR_CODE_SAME) ? acc2_q : dec2_q) : dec1_q;
    raw_t   = rise ? acc_sel : dec_sel;
    time_c  = (raw_t <= `ADR_TIME_SHORT) ? `ADR_TIME_FLOOR : raw_t;
    f_hi    = (set_freq_i > acc_q[31:16]) ? set_freq_i : acc_q[31:16];
    s_on    = (pat_q == `ADR_PAT_S_A) && (f_hi >= base_q);
    ref_chz = (pat_q == `ADR_PAT_S_A) ? base_q : 16'(ref_q) * `ADR_CHZ_PER_HZ;
  end

  // --------------------------------------------------------------------
  // slope calculation, rerun continuously so changes land next tick
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      calc_q    <= adr_pkg::ADR_CALC_IDLE;
      div_go_q  <= 1'b0;
      div_num_q <= '0;
      div_den_q <= '0;
      tmr_q     <= `ADR_TIME_FLOOR;
      ref_l_q   <= '0;
      f_l_q     <= '0;
      step_q    <= '0;
    end else begin
      div_go_q <= 1'b0;
      unique case (calc_q)
        adr_pkg::ADR_CALC_IDLE: begin
          tmr_q    <= time_c;
          ref_l_q  <= ref_chz;
          f_l_q    <= f_hi;
          div_go_q <= 1'b1;
          if (s_on) begin
            // total time in ms = 10 T (4 f^2 + 5 fb^2) / (9 fb^2), ms keeps short ramps exact
            div_num_q <= 64'(time_c) * `ADR_TIME_SCALE
                         * (`ADR_S_COEF_SQ * adr_sq(f_hi) + `ADR_S_COEF_LIN * adr_sq(base_q));
            div_den_q <= `ADR_S_COEF_DEN * adr_sq(base_q);
            calc_q    <= adr_pkg::ADR_CALC_TIME;
          end else begin
            // slope = reference / time
            div_num_q <= 64'(ref_chz) << `ADR_FRAC;
            div_den_q <= 64'(time_c) * `ADR_TIME_SCALE;
            calc_q    <= adr_pkg::ADR_CALC_STEP;
          end
        end
        adr_pkg::ADR_CALC_TIME: begin
          if (div_done) begin
            div_num_q <= 64'(f_l_q) << `ADR_FRAC;
            div_den_q <= (div_quo < `ADR_TIME_SCALE * 64'(`ADR_TIME_FLOOR)) ?
                         `ADR_TIME_SCALE * 64'(`ADR_TIME_FLOOR) : div_quo;
            div_go_q  <= 1'b1;
            calc_q    <= adr_pkg::ADR_CALC_STEP;
          end
        end
        adr_pkg::ADR_CALC_STEP: begin
          if (div_done) begin
            step_q <= (|div_quo[63:32]) ? 32'hFFFFFFFF : div_quo[31:0];
            calc_q <= adr_pkg::ADR_CALC_IDLE;
          end
        end
      endcase
    end
  end

  adr_divider #(
    .WIDTH (64)
  ) u_div (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .start_i   (div_go_q),
    .num_i     (div_num_q),
    .den_i     (div_den_q),
    .quo_o     (div_quo),
    .done_o    (div_done)
  );

  // --------------------------------------------------------------------
  // ramp accumulator, 16 fraction bits
  // --------------------------------------------------------------------
  always_comb begin
    up_sum = 33'(acc_q) + 33'(step_q);
  end

  // step toward set frequency, clamp at it, reverse as needed
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      acc_q <= '0;
    end else if (tick_q) begin
      if (rise) begin
        acc_q <= (up_sum >= 33'(set_fp)) ? set_fp : up_sum[31:0];
      end else if (acc_q > set_fp) begin
        acc_q <= ((acc_q - set_fp) <= step_q) ? set_fp : acc_q - step_q;
      end
    end
  end

  // status flops feeding outputs
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      busy_q   <= 1'b0;
      second_q <= 1'b0;
    end else begin
      busy_q   <= (acc_q != set_fp);
      second_q <= sel;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign out_freq_o   = acc_q[31:16];
  assign ramp_busy_o  = busy_q;
  assign second_set_o = second_q;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  AST_NO_OVERSHOOT_UP: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (tick_q && rise && $stable(set_freq_i)) |=> (acc_q <= set_fp))
    else $error("ramp passed set frequency going up");

  AST_NO_OVERSHOOT_DN: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (tick_q && acc_q > set_fp && $stable(set_freq_i)) |=> (acc_q >= set_fp))
    else $error("ramp passed set frequency going down");

  AST_HOLD_BETWEEN_TICKS: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !tick_q |=> $stable(acc_q))
    else $error("output moved without a tick");

  AST_REF_RANGE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (ref_q >= `ADR_REF_MIN) && (ref_q <= `ADR_REF_MAX))
    else $error("reference frequency out of range");

  AST_TIME_FLOOR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (calc_q == adr_pkg::ADR_CALC_IDLE && raw_t <= `ADR_TIME_SHORT) |=> (tmr_q == `ADR_TIME_FLOOR))
    else $error("short ramp time not raised to floor");

  AST_SECOND_ACCEL: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (calc_q == adr_pkg::ADR_CALC_IDLE && sel && rise && acc2_q > `ADR_TIME_SHORT) |=> (tmr_q == $past(acc2_q)))
    else $error("second accel time not used");

  AST_SECOND_DECEL_SAME: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (calc_q == adr_pkg::ADR_CALC_IDLE && sel && !rise && dec2_q == `ADR_CODE_SAME
     && acc2_q > `ADR_TIME_SHORT) |=> (tmr_q == $past(acc2_q)))
    else $error("second decel code not mapped to second accel");

  AST_GAIN_KEEP: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (reg_wr_i && reg_addr_i == `ADR_OFS_REF) |=> ($stable(gain_a_q) && $stable(gain_b_q)))
    else $error("gain changed by reference write");

  AST_S_BASE_REF: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (calc_q == adr_pkg::ADR_CALC_IDLE && pat_q == `ADR_PAT_S_A) |=> (ref_l_q == $past(base_q)))
    else $error("s-pattern a not referred to base frequency");

  AST_SELECT_ROUTE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (term_in_i == '0) |=> !second_set_o)
    else $error("second set selected with no terminal active");

endmodule

// ===== adr_stage_model.sv
/*
  Output stage model: follows the commanded frequency and counts bad steps.
  Assumes the ramp generator's clock, reset and set frequency.
*/
`timescale 1ns/100ps

module adr_stage_model (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // commanded and set frequency
  input  wire logic [15:0] out_freq_i,
  input  wire logic [15:0] set_freq_i,
  // count of bad steps
  output int               bad_o
);
  logic [15:0] prev_q;

  // ------------------------------------------------------------------
  // step watch
  // ------------------------------------------------------------------
  // a step heads for the set value and never passes it
  always_ff @(posedge clk_sys_i) begin
    prev_q <= out_freq_i;
    if (!rst_b_i) begin
      bad_o <= 0;
    end else if (out_freq_i > prev_q && out_freq_i > set_freq_i) begin
      bad_o <= bad_o + 1;
    end else if (out_freq_i < prev_q && out_freq_i < set_freq_i) begin
      bad_o <= bad_o + 1;
    end
  end
endmodule

// ===== accel_decel_ramp_timing_tb_top.sv
/*
  Self-checking bench for the ramp generator with an output stage model.
  Assumes adr_defines.svh, the design files and adr_stage_model come first.
*/
`timescale 1ns/100ps
`include "adr_defines.svh"
`define CHK(a, e) chk_v(64'(a), 64'(e))

module accel_decel_ramp_timing_tb_top;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [4:0]  term_in   = 5'h00;
  logic [15:0] set_freq  = 16'h0000;
  logic [31:0] rdata;
  logic [15:0] out_freq;
  logic        busy;
  logic        sec;
  logic [31:0] rv;
  int          bad;
  int          err_count = 0;
  int          checked   = 0;
  int          n, k, r, f;
  logic [7:0]  rst_a [11] = '{`ADR_OFS_ACC1, `ADR_OFS_DEC1, `ADR_OFS_ACC2, `ADR_OFS_DEC2, `ADR_OFS_REF,
                              `ADR_OFS_PAT, `ADR_OFS_BASE, `ADR_OFS_GAIN_A, `ADR_OFS_GAIN_B, `ADR_OFS_TERM0, 8'h80};
  logic [31:0] rst_v [11] = '{`ADR_TIME_RST_SMALL, `ADR_TIME_RST_SMALL, `ADR_TIME_RST_SMALL, `ADR_CODE_SAME,
                              `ADR_REF_RST, `ADR_PAT_LINEAR, `ADR_BASE_RST, 0, 0, 0, 0};
  logic [7:0]  cl_a [6] = '{`ADR_OFS_REF, `ADR_OFS_REF, `ADR_OFS_ACC1, `ADR_OFS_PAT, `ADR_OFS_PAT, `ADR_OFS_PAT};
  logic [31:0] cl_w [6] = '{0, 500, 400000, `ADR_PAT_S_B, 3, `ADR_PAT_S_A};
  logic [31:0] cl_e [6] = '{`ADR_REF_MIN, `ADR_REF_MAX, `ADR_TIME_MAX, `ADR_PAT_S_B, `ADR_PAT_S_B, `ADR_PAT_S_A};

  // ------------------------------------------------------------------
  // clock, design and far side
  // ------------------------------------------------------------------
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  adr_ramp #(.TICK_CYCLES(250), .LARGE_RATING(1'b0), .TERM_COUNT(5)) DUT (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .term_in_i(term_in),
    .set_freq_i(set_freq), .out_freq_o(out_freq), .ramp_busy_o(busy), .second_set_o(sec));

  adr_stage_model MDL (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .out_freq_i(out_freq), .set_freq_i(set_freq), .bad_o(bad));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_v(input logic [63:0] a, input logic [63:0] e);
    checked++;
    if (a !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input int d);
    @(posedge clk_sys_i);
    reg_addr  <= a;
    reg_wdata <= 32'(d);
    reg_wr    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd <= 1'b0;
    #1 rv = rdata;
  endtask

  // slope is recomputed after a settings change
  task automatic settle;
    repeat (300) @(posedge clk_sys_i);
  endtask

  // new set value, then count output steps until it settles
  task automatic ramp(input logic [15:0] t);
    logic [15:0] p;
    int c;
    logic hi;
    p = out_freq;
    hi = 1'b0;
    n = 0;
    @(posedge clk_sys_i);
    set_freq <= t;
    for (c = 0; c < 40000 && (out_freq !== t || busy !== 1'b0); c++) begin
      @(posedge clk_sys_i);
      #1;
      if (out_freq !== p) n++;
      if (busy === 1'b1) hi = 1'b1;
      p = out_freq;
    end
    if (c >= 40000) begin
      err_count++;
      summarize();
    end
    `CHK(out_freq, t);
    `CHK(hi, 1'b1);
  endtask

  function automatic logic near(input int a, input int e);
    return (a >= e - 1) && (a <= e + 1);
  endfunction

  // linear: ticks to cover distance d at reference r and time t
  function automatic int ticks(input longint d, input longint r, input longint t);
    longint s;
    s = (r * 655360) / ((t <= 3) ? 4 : t);
    return int'((d * 65536 + s - 1) / s);
  endfunction

  // s-pattern a: total ms from 0 to d with base b and time t
  function automatic int sa(input longint d, input longint b, input longint t);
    if (d < b) return int'((t * 10 * d + b - 1) / b);
    return int'((t * 10 * (4 * d * d + 5 * b * b) + 9 * b * b - 1) / (9 * b * b));
  endfunction

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(32'hB8A06AA1));
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    for (k = 0; k < 11; k++) begin
      rd(rst_a[k]);
      `CHK(rv, rst_v[k]);
    end
    wr(`ADR_OFS_GAIN_A, 16'h1234);
    for (k = 0; k < 6; k++) begin
      wr(cl_a[k], cl_w[k]);
      rd(cl_a[k]);
      `CHK(rv, cl_e[k]);
    end
    rd(`ADR_OFS_GAIN_A);
    `CHK(rv, 32'h1234);
    $display("test registers done");
    wr(`ADR_OFS_PAT, `ADR_PAT_LINEAR);
    for (k = 0; k < 2; k++) begin
      r = 50 + $urandom % 351;
      f = 100 + $urandom % 1900;
      wr(`ADR_OFS_ACC1, 10);
      wr(`ADR_OFS_DEC1, 20);
      wr(`ADR_OFS_REF, r);
      settle();
      ramp(16'(f));
      `CHK(near(n, ticks(f, r, 10)), 1'b1);
      rd(`ADR_OFS_STAT);
      `CHK(rv[15:0], 16'(f));
      ramp(16'h0000);
      `CHK(near(n, ticks(f, r, 20)), 1'b1);
    end
    $display("test linear done");
    k = $urandom % 5;
    wr(8'(`ADR_OFS_TERM0 + 4 * k), `ADR_FN_SECOND_SET);
    wr(`ADR_OFS_ACC2, 20);
    wr(`ADR_OFS_REF, 100);
    @(posedge clk_sys_i);
    term_in <= 5'h1F ^ (5'h01 << k);
    settle();
    `CHK(sec, 1'b0);
    @(posedge clk_sys_i);
    term_in <= 5'h01 << k;
    settle();
    `CHK(sec, 1'b1);
    ramp(16'd1000);
    `CHK(near(n, ticks(1000, 100, 20)), 1'b1);
    ramp(16'h0000);
    `CHK(near(n, ticks(1000, 100, 20)), 1'b1);
    @(posedge clk_sys_i);
    term_in <= 5'h00;
    $display("test second set done");
    wr(`ADR_OFS_ACC1, 3);
    wr(`ADR_OFS_DEC1, 0);
    settle();
    ramp(16'd1000);
    `CHK(near(n, ticks(1000, 100, 3)), 1'b1);
    ramp(16'h0000);
    `CHK(near(n, ticks(1000, 100, 0)), 1'b1);
    wr(`ADR_OFS_PAT, `ADR_PAT_S_B);
    settle();
    ramp(16'd1000);
    `CHK(near(n, ticks(1000, 100, 3)), 1'b1);
    ramp(16'h0000);
    $display("test short time done");
    wr(`ADR_OFS_PAT, `ADR_PAT_S_A);
    wr(`ADR_OFS_ACC1, 4);
    wr(`ADR_OFS_DEC1, 4);
    settle();
    ramp(16'd2500);
    `CHK(near(n, sa(2500, `ADR_BASE_RST, 4)), 1'b1);
    ramp(16'h0000);
    settle();
    ramp(16'd7500);
    `CHK(near(n, sa(7500, `ADR_BASE_RST, 4)), 1'b1);
    `CHK(bad, 0);
    $display("test s pattern done");
    summarize();
  end
endmodule
